// ==== common/rsc_pkg.sv ====
package rsc_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_DECEL  = 8'h04;
    localparam logic [7:0] OFF_DCB    = 8'h08;
    localparam logic [7:0] OFF_PREX   = 8'h0c;
    localparam logic [7:0] OFF_HOLD   = 8'h10;
    localparam logic [7:0] OFF_HOST   = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;

    // control field positions
    localparam int CTRL_SRC_LSB  = 0;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_START    = 4;
    localparam int CTRL_STOP     = 5;
    localparam int CTRL_INH      = 6;
    localparam int CTRL_W        = 7;

    // host command bits
    localparam int HOST_RUN = 0;
    localparam int HOST_REV = 1;
    localparam int HOST_STP = 2;

    // command sources and terminal modes
    localparam logic [1:0] SRC_KEYPAD = 2'h0;
    localparam logic [1:0] SRC_TERM   = 2'h1;
    localparam logic [1:0] SRC_HOST   = 2'h2;
    localparam logic [1:0] TM_RUN_DIR = 2'h0;
    localparam logic [1:0] TM_FWD_REV = 2'h1;
    localparam logic [1:0] TM_FSR     = 2'h2;
    localparam logic [1:0] TM_RSD     = 2'h3;

    // reset values
    localparam logic [6:0]  CTRL_RST  = 7'h00;
    localparam logic [15:0] DECEL_RST = 16'h3a98;
    localparam logic [15:0] DCB_RST   = 16'h0000;
    localparam logic [15:0] PREX_RST  = 16'h0000;
    localparam logic [15:0] HOLD_RST  = 16'h0000;

    // timing
    localparam int CLK_NS     = 10;
    localparam int TICK_NS    = 1000000;
    localparam int TICK_CYC   = TICK_NS / CLK_NS;
    localparam int UV_REP_MS  = 5000;
    localparam int BLINK_MS   = 250;
    localparam logic [15:0] UV_REP_TICKS = 16'(UV_REP_MS);
    localparam logic [15:0] BLINK_TICKS  = 16'(BLINK_MS);

    typedef struct packed {
        logic       reverse_inhibit;
        logic       stop_method_select;
        logic       start_method_select;
        logic [1:0] terminal_mode_select;
        logic [1:0] command_source_select;
    } rsc_cfg_t;

    typedef struct packed {
        logic run;
        logic rev;
        logic stop;
    } rsc_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_DCB, ST_PREX, ST_HOLD, ST_TRACK, ST_RUN, ST_DECEL
    } rsc_state_t;

endpackage : rsc_pkg

// ==== src/rsc_run_stop.sv ====
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
// Function
// - power-on prompt after initialization done
// - undervolt prompt, any key dismisses it
// - undervolt prompt returns after 5s idle
// - contactor closed swaps to power-on prompt
// - start without contactor raises soft warning
// - keypad run/stop keys, run blocked by trip
// - run led steady running, flicker decelerating
// - terminal source uses terminal mode decode
// - host source takes commands only from host
// - direct start: brake, pre-excite, hold
// - speed tracking start from rotating frequency
// - ramp stop over first decel time
// - coast stop cuts output immediately
// - terminal mode field picks four schemes
// - mode 0 run level, direction level
// - reverse inhibit masks reverse from direction terminal; mode 1 run+dir still stops
// - mode 1 forward/reverse, both means stop
// - two-line stop needs run release, reassert
// - mode 2 edge starts, closed stop level
// - mode 3 edge start, dir level, stop
module rsc_run_stop #(
    parameter int TICK_CYC = rsc_pkg::TICK_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        key_run,
    input  wire logic        key_stop,
    input  wire logic        key_any,
    input  wire logic        term_run,
    input  wire logic        term_dir,
    input  wire logic        term_stop,
    input  wire logic        ext_stop,
    input  wire logic        trip_active,
    input  wire logic        init_done,
    input  wire logic        bus_undervolt,
    input  wire logic        softstart_closed,
    input  wire logic        track_lock,
    output logic             drive_enable,
    output logic             drive_reverse,
    output logic             dc_brake_on,
    output logic             pre_excite_on,
    output logic             start_hold_on,
    output logic             track_on,
    output logic             ramp_down_on,
    output logic             run_led,
    output logic             prompt_power_on,
    output logic             prompt_undervolt,
    output logic             warn_soft_start
);

    function automatic logic rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction : rise

    // ---------------- ms tick divider
    logic [31:0] div_cnt;
    logic        tick;
    wire         div_end = (div_cnt == 32'(TICK_CYC - 1));

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            div_cnt <= 32'h0;
            tick    <= 1'b0;
        end else begin
            div_cnt <= div_end ? 32'h0 : div_cnt + 32'h1;
            tick    <= div_end;
        end
    end

    // ---------------- apb slave
    rsc_pkg::rsc_cfg_t cfg;
    logic [15:0] decel_ms;
    logic [15:0] dcb_ms;
    logic [15:0] prex_ms;
    logic [15:0] hold_ms;
    rsc_pkg::rsc_cmd_t host_cmd;
    logic [31:0] status_word;

    wire acc    = psel & penable;
    wire done   = acc & pready;
    wire wr     = done & pwrite;
    wire a_ctrl = (paddr == rsc_pkg::OFF_CTRL);
    wire a_dec  = (paddr == rsc_pkg::OFF_DECEL);
    wire a_dcb  = (paddr == rsc_pkg::OFF_DCB);
    wire a_prex = (paddr == rsc_pkg::OFF_PREX);
    wire a_hold = (paddr == rsc_pkg::OFF_HOLD);
    wire a_host = (paddr == rsc_pkg::OFF_HOST);
    wire a_stat = (paddr == rsc_pkg::OFF_STATUS);
    wire mapped = a_ctrl | a_dec | a_dcb | a_prex | a_hold | a_host | a_stat;

    logic [31:0] rd_mux;
    always_comb begin
        if (a_ctrl)      rd_mux = {25'h0, cfg};
        else if (a_dec)  rd_mux = {16'h0, decel_ms};
        else if (a_dcb)  rd_mux = {16'h0, dcb_ms};
        else if (a_prex) rd_mux = {16'h0, prex_ms};
        else if (a_hold) rd_mux = {16'h0, hold_ms};
        else if (a_stat) rd_mux = status_word;
        else             rd_mux = 32'h0;
    end

    // answer one cycle into the access phase
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc & ~pready;
            prdata  <= (acc & ~pready & ~pwrite) ? rd_mux : 32'h0;
            pslverr <= acc & ~pready & ~mapped;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cfg      <= rsc_pkg::rsc_cfg_t'(rsc_pkg::CTRL_RST);
            decel_ms <= rsc_pkg::DECEL_RST;
            dcb_ms   <= rsc_pkg::DCB_RST;
            prex_ms  <= rsc_pkg::PREX_RST;
            hold_ms  <= rsc_pkg::HOLD_RST;
            host_cmd <= '0;
        end else begin
            // host commands are one-cycle pulses
            host_cmd <= '0;
            if (wr && a_ctrl)
                cfg <= rsc_pkg::rsc_cfg_t'(pwdata[rsc_pkg::CTRL_W-1:0]);
            if (wr && a_dec)
                decel_ms <= pwdata[15:0];
            if (wr && a_dcb)
                dcb_ms <= pwdata[15:0];
            if (wr && a_prex)
                prex_ms <= pwdata[15:0];
            if (wr && a_hold)
                hold_ms <= pwdata[15:0];
            if (wr && a_host)
                host_cmd <= {pwdata[rsc_pkg::HOST_RUN],
                             pwdata[rsc_pkg::HOST_REV],
                             pwdata[rsc_pkg::HOST_STP]};
        end
    end

    // ---------------- input edges
    logic p_key_run;
    logic p_key_stop;
    logic p_term_run;
    logic p_term_dir;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            p_key_run  <= 1'b0;
            p_key_stop <= 1'b0;
            p_term_run <= 1'b0;
            p_term_dir <= 1'b0;
        end else begin
            p_key_run  <= key_run;
            p_key_stop <= key_stop;
            p_term_run <= term_run;
            p_term_dir <= term_dir;
        end
    end

    wire e_key_run  = rise(key_run, p_key_run);
    wire e_key_stop = rise(key_stop, p_key_stop);
    wire e_run      = rise(term_run, p_term_run);
    wire e_dir      = rise(term_dir, p_term_dir);

    // ---------------- command decode
    rsc_pkg::rsc_state_t state;
    rsc_pkg::rsc_state_t next_state;
    logic relaunch_block;
    logic running;
    logic reverse;

    wire [1:0] src  = cfg.command_source_select;
    wire [1:0] mode = cfg.terminal_mode_select;
    wire inh        = cfg.reverse_inhibit;
    wire src_key    = (src == rsc_pkg::SRC_KEYPAD);
    wire src_term   = (src == rsc_pkg::SRC_TERM);
    wire src_host   = (src == rsc_pkg::SRC_HOST);
    wire two_line   = (mode == rsc_pkg::TM_RUN_DIR) |
                      (mode == rsc_pkg::TM_FWD_REV);
    wire stop_m2    = (mode == rsc_pkg::TM_FSR) & ~term_stop;
    wire stop_m3    = (mode == rsc_pkg::TM_RSD) & term_stop;
    wire stop_3l    = stop_m2 | stop_m3;

    wire m0_want    = term_run;
    wire m0_rev     = term_dir & ~inh;
    wire m1_fwd     = term_run & ~term_dir;
    wire m1_revl    = term_dir & ~term_run & ~inh;
    wire tl_want    = (mode == rsc_pkg::TM_RUN_DIR) ? m0_want
                    : (m1_fwd | m1_revl);
    wire tl_rev     = (mode == rsc_pkg::TM_RUN_DIR) ? m0_rev : m1_revl;

    wire e_fwd_3l   = e_run & ~stop_3l;
    wire e_rev_3l   = e_dir & ~stop_3l & ~inh &
                      (mode == rsc_pkg::TM_FSR);
    wire tr_rev     = (mode == rsc_pkg::TM_FSR) ? e_rev_3l
                    : (term_dir & ~inh);

    wire stop_force = (src_term | src_key) & (e_key_stop | ext_stop);

    logic start_req;
    logic start_rev;
    logic stop_req;
    always_comb begin
        start_req = 1'b0;
        start_rev = 1'b0;
        stop_req  = 1'b0;
        if (src_key) begin
            start_req = e_key_run & ~trip_active;
            stop_req  = e_key_stop;
        end else if (src_host) begin
            start_req = host_cmd.run;
            start_rev = host_cmd.rev & ~inh;
            stop_req  = host_cmd.stop;
        end else if (src_term && two_line) begin
            start_req = tl_want & ~relaunch_block & ~running;
            start_rev = tl_rev;
            stop_req  = stop_force | (running & ~tl_want);
        end else if (src_term) begin
            start_req = e_fwd_3l | e_rev_3l;
            start_rev = tr_rev;
            stop_req  = stop_force | stop_3l;
        end
    end

    wire blk_set = stop_force & src_term & two_line & tl_want;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            relaunch_block <= 1'b0;
        else if (blk_set)
            relaunch_block <= 1'b1;
        else if (!tl_want)
            relaunch_block <= 1'b0;
    end

    // ---------------- soft start and prompts
    wire uv_active = bus_undervolt & ~softstart_closed;
    logic warn_soft;
    logic uv_dismiss;
    logic [15:0] uv_cnt;
    logic init_seen;

    wire start_ok   = start_req & ~running & softstart_closed &
                      ~trip_active;
    wire soft_block = start_req & ~running & ~softstart_closed;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            warn_soft <= 1'b0;
        else if (soft_block)
            warn_soft <= 1'b1;
        else if (softstart_closed)
            warn_soft <= 1'b0;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            init_seen <= 1'b0;
        else if (init_done)
            init_seen <= 1'b1;
    end

    wire uv_rep = tick & (uv_cnt == rsc_pkg::UV_REP_TICKS - 16'h1);
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            uv_dismiss <= 1'b0;
            uv_cnt     <= 16'h0;
        end else if (!uv_active) begin
            uv_dismiss <= 1'b0;
            uv_cnt     <= 16'h0;
        end else if (key_any) begin
            uv_dismiss <= 1'b1;
            uv_cnt     <= 16'h0;
        end else if (uv_dismiss && uv_rep) begin
            uv_dismiss <= 1'b0;
            uv_cnt     <= 16'h0;
        end else if (uv_dismiss && tick) begin
            uv_cnt <= uv_cnt + 16'h1;
        end
    end

    // ---------------- start/stop sequencer
    logic [15:0] ph_cnt;
    wire ph_zero = (ph_cnt == 16'h0);
    wire ph_last = tick & (ph_cnt == 16'h1);

    wire [2:0] dir_pick = (dcb_ms != 16'h0)  ? 3'h1
                        : (prex_ms != 16'h0) ? 3'h2 : 3'h3;

    always_comb begin
        next_state = state;
        case (state)
            rsc_pkg::ST_IDLE: begin
                if (start_ok && cfg.start_method_select)
                    next_state = rsc_pkg::ST_TRACK;
                else if (start_ok && dir_pick == 3'h1)
                    next_state = rsc_pkg::ST_DCB;
                else if (start_ok && dir_pick == 3'h2)
                    next_state = rsc_pkg::ST_PREX;
                else if (start_ok)
                    next_state = rsc_pkg::ST_HOLD;
            end
            rsc_pkg::ST_DCB: begin
                if (ph_last && prex_ms != 16'h0)
                    next_state = rsc_pkg::ST_PREX;
                else if (ph_last)
                    next_state = rsc_pkg::ST_HOLD;
            end
            rsc_pkg::ST_PREX: begin
                if (ph_last)
                    next_state = rsc_pkg::ST_HOLD;
            end
            rsc_pkg::ST_HOLD: begin
                if (ph_zero || ph_last)
                    next_state = rsc_pkg::ST_RUN;
            end
            rsc_pkg::ST_TRACK: begin
                if (track_lock)
                    next_state = rsc_pkg::ST_RUN;
            end
            rsc_pkg::ST_DECEL: begin
                if (ph_zero || ph_last)
                    next_state = rsc_pkg::ST_IDLE;
            end
            default: next_state = state;
        endcase
        if (running && (stop_req || trip_active) &&
            (cfg.stop_method_select || trip_active))
            next_state = rsc_pkg::ST_IDLE;
        else if (running && stop_req && state != rsc_pkg::ST_DECEL)
            next_state = rsc_pkg::ST_DECEL;
    end

    wire entering = (next_state != state);
    logic [15:0] next_ph;
    always_comb begin
        next_ph = ph_cnt;
        if (entering) begin
            case (next_state)
                rsc_pkg::ST_DCB:   next_ph = dcb_ms;
                rsc_pkg::ST_PREX:  next_ph = prex_ms;
                rsc_pkg::ST_HOLD:  next_ph = hold_ms;
                rsc_pkg::ST_DECEL: next_ph = decel_ms;
                default:           next_ph = 16'h0;
            endcase
        end else if (tick && !ph_zero) begin
            next_ph = ph_cnt - 16'h1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state  <= rsc_pkg::ST_IDLE;
            ph_cnt <= 16'h0;
        end else begin
            state  <= next_state;
            ph_cnt <= next_ph;
        end
    end

    always_comb running = (state != rsc_pkg::ST_IDLE);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            reverse <= 1'b0;
        else if (state == rsc_pkg::ST_IDLE && start_ok)
            reverse <= start_rev;
    end

    // ---------------- run led blink
    logic [15:0] blink_cnt;
    logic        blink;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            blink_cnt <= 16'h0;
            blink     <= 1'b0;
        end else if (state != rsc_pkg::ST_DECEL) begin
            blink_cnt <= 16'h0;
            blink     <= 1'b0;
        end else if (tick &&
                     blink_cnt == rsc_pkg::BLINK_TICKS - 16'h1) begin
            blink_cnt <= 16'h0;
            blink     <= ~blink;
        end else if (tick) begin
            blink_cnt <= blink_cnt + 16'h1;
        end
    end

    // ---------------- registered outputs
    wire next_dec = (next_state == rsc_pkg::ST_DECEL);
    wire next_run = (next_state != rsc_pkg::ST_IDLE);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            drive_enable     <= 1'b0;
            drive_reverse    <= 1'b0;
            dc_brake_on      <= 1'b0;
            pre_excite_on    <= 1'b0;
            start_hold_on    <= 1'b0;
            track_on         <= 1'b0;
            ramp_down_on     <= 1'b0;
            run_led          <= 1'b0;
            prompt_power_on  <= 1'b0;
            prompt_undervolt <= 1'b0;
            warn_soft_start  <= 1'b0;
        end else begin
            drive_enable     <= next_run;
            drive_reverse    <= reverse & running;
            dc_brake_on      <= (next_state == rsc_pkg::ST_DCB);
            pre_excite_on    <= (next_state == rsc_pkg::ST_PREX);
            start_hold_on    <= (next_state == rsc_pkg::ST_HOLD);
            track_on         <= (next_state == rsc_pkg::ST_TRACK);
            ramp_down_on     <= next_dec;
            run_led          <= next_run & (~next_dec | blink);
            prompt_power_on  <= init_seen & ~uv_active;
            prompt_undervolt <= uv_active & ~uv_dismiss;
            warn_soft_start  <= warn_soft;
        end
    end

    always_comb status_word = {21'h0, state, relaunch_block, run_led,
                               warn_soft, prompt_undervolt,
                               prompt_power_on, ramp_down_on,
                               reverse, running};

endmodule : rsc_run_stop

// ==== verif/rsc_run_stop_assertions.sv ====
`timescale 1ns/1ps
module rsc_run_stop_chk (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic psel,
    input  wire logic penable,
    input  wire logic pready,
    input  wire logic init_done,
    input  wire logic bus_undervolt,
    input  wire logic softstart_closed,
    input  wire logic drive_enable,
    input  wire logic ramp_down_on,
    input  wire logic run_led,
    input  wire logic prompt_power_on,
    input  wire logic prompt_undervolt,
    input  wire logic warn_soft_start
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    // exactly one wait state per transfer
    chk_apb_wait: assert property (psel && $rose(penable) |=> pready)
        else $error("apb answer not after one wait state");
    chk_apb_pulse: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    chk_prompt_on: assert property
        ((init_done && !bus_undervolt)[*3] |-> prompt_power_on)
        else $error("power-on prompt missing");
    chk_uv_gone: assert property
        ((!bus_undervolt && softstart_closed)[*2] |-> !prompt_undervolt)
        else $error("undervolt prompt kept after recovery");
    // output lags the internal flag, hence three samples
    chk_warn_clear: assert property
        (softstart_closed[*3] |-> !warn_soft_start)
        else $error("soft-start warning kept with contactor closed");
    chk_soft_block: assert property
        ((!softstart_closed)[*2] ##0 !drive_enable |=> !drive_enable)
        else $error("drive started with contactor open");
    chk_ramp_out: assert property (ramp_down_on |-> drive_enable)
        else $error("ramp down without output");
    chk_led_idle: assert property ((!drive_enable)[*3] |-> !run_led)
        else $error("run led lit while idle");

    cover property (ramp_down_on && run_led);
    cover property (warn_soft_start);
    cover property (prompt_undervolt);
endmodule : rsc_run_stop_chk

bind rsc_run_stop rsc_run_stop_chk u_rsc_run_stop_chk (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pready(pready), .init_done(init_done),
    .bus_undervolt(bus_undervolt), .softstart_closed(softstart_closed),
    .drive_enable(drive_enable), .ramp_down_on(ramp_down_on),
    .run_led(run_led), .prompt_power_on(prompt_power_on),
    .prompt_undervolt(prompt_undervolt),
    .warn_soft_start(warn_soft_start)
);

// ==== verif/rsc_panel.sv ====
`timescale 1ns/1ps
module rsc_panel (
    input  wire logic mclk,
    output logic      key_run,
    output logic      key_stop,
    output logic      key_any,
    output logic      term_run,
    output logic      term_dir,
    output logic      term_stop,
    output logic      ext_stop
);
    initial begin
        {key_run, key_stop, key_any} = 3'h0;
        {term_run, term_dir, term_stop, ext_stop} = 4'h0;
    end
    // key held three edges, a contact never bounces shorter
    task press(input logic [1:0] k);
        {key_run, key_stop, key_any} <= {k, 1'h1};
        repeat (3) @(posedge mclk);
        {key_run, key_stop, key_any} <= 3'h0;
        @(posedge mclk);
    endtask : press
    task lines(input logic [3:0] v);
        {term_run, term_dir, term_stop, ext_stop} <= v;
        repeat (2) @(posedge mclk);
    endtask : lines
endmodule : rsc_panel

// ==== verif/rsc_run_stop_bench.sv ====
`timescale 1ns/1ps
module rsc_run_stop_bench;
    logic        mclk = 1'h0;
    logic        rstn = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er;
    logic        trip_active = 1'h0, init_done = 1'h0;
    logic        bus_undervolt = 1'h0, softstart_closed = 1'h0;
    logic        track_lock = 1'h0;
    logic        key_run, key_stop, key_any, term_run, term_dir;
    logic        term_stop, ext_stop, drive_enable, drive_reverse;
    logic        dc_brake_on, pre_excite_on, start_hold_on, track_on;
    logic        ramp_down_on, run_led, prompt_power_on;
    logic        prompt_undervolt, warn_soft_start;
    int          miscompares = 0;
    int          checks = 0;

    always #5 mclk = ~mclk;
    rsc_panel u_rsc_panel (
        .mclk(mclk), .key_run(key_run), .key_stop(key_stop),
        .key_any(key_any), .term_run(term_run), .term_dir(term_dir),
        .term_stop(term_stop), .ext_stop(ext_stop)
    );
    // short tick keeps the 5000-tick reprompt inside the run
    rsc_run_stop #(.TICK_CYC(4)) u_rsc_run_stop (
        .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .key_run(key_run), .key_stop(key_stop), .key_any(key_any),
        .term_run(term_run), .term_dir(term_dir),
        .term_stop(term_stop), .ext_stop(ext_stop),
        .trip_active(trip_active), .init_done(init_done),
        .bus_undervolt(bus_undervolt),
        .softstart_closed(softstart_closed), .track_lock(track_lock),
        .drive_enable(drive_enable), .drive_reverse(drive_reverse),
        .dc_brake_on(dc_brake_on), .pre_excite_on(pre_excite_on),
        .start_hold_on(start_hold_on), .track_on(track_on),
        .ramp_down_on(ramp_down_on), .run_led(run_led),
        .prompt_power_on(prompt_power_on),
        .prompt_undervolt(prompt_undervolt),
        .warn_soft_start(warn_soft_start)
    );

    task nap(input int n);
        repeat (n) @(posedge mclk);
    endtask : nap
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        nap(1);
        penable <= 1'h1;
        do nap(1); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        nap(1);
    endtask : apb
    task ctrl(input logic [7:0] v);
        apb(1'h1, rsc_pkg::OFF_CTRL, {24'h0, v});
    endtask : ctrl
    task wait_de(input logic e);
        for (int n = 0; n < 600 && drive_enable !== e; n++)
            nap(1);
        chk(drive_enable, e);
    endtask : wait_de
    task close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    initial begin
        nap(40000);
        miscompares++;
        close_out;
    end

    initial begin
        nap(6);
        rstn <= 1'h1;
        nap(1);
        chk({drive_enable, prompt_power_on, pready}, 3'h0);
        apb(1'h0, rsc_pkg::OFF_DECEL, 32'h0);
        chk(rd, 32'h3a98);
        apb(1'h0, 8'h40, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        apb(1'h1, rsc_pkg::OFF_DECEL, 32'h12c);
        init_done <= 1'h1;
        bus_undervolt <= 1'h1;
        nap(4);
        chk(prompt_undervolt, 1'h1);
        u_rsc_panel.press(2'h2);
        nap(2);
        chk({prompt_undervolt, warn_soft_start, drive_enable}, 3'h2);
        nap(19950);
        chk(prompt_undervolt, 1'h0);
        nap(80);
        chk(prompt_undervolt, 1'h1);
        bus_undervolt <= 1'h0;
        softstart_closed <= 1'h1;
        nap(5);
        chk({prompt_undervolt, prompt_power_on, warn_soft_start}, 3'h2);
        trip_active <= 1'h1;
        u_rsc_panel.press(2'h2);
        nap(4);
        chk(drive_enable, 1'h0);
        trip_active <= 1'h0;
        u_rsc_panel.press(2'h2);
        wait_de(1'h1);
        nap(4);
        chk(run_led, 1'h1);
        u_rsc_panel.press(2'h1);
        chk({ramp_down_on, run_led}, 2'h2);
        nap(1050);
        chk({ramp_down_on, run_led}, 2'h3);
        wait_de(1'h0);
        u_rsc_panel.press(2'h2);
        wait_de(1'h1);
        ctrl(8'h20);
        u_rsc_panel.press(2'h1);
        chk(drive_enable, 1'h0);
        apb(1'h1, rsc_pkg::OFF_DCB, 32'h4);
        apb(1'h1, rsc_pkg::OFF_PREX, 32'h4);
        apb(1'h1, rsc_pkg::OFF_HOLD, 32'h4);
        u_rsc_panel.press(2'h2);
        nap(2);
        chk(dc_brake_on, 1'h1);
        nap(16);
        chk(pre_excite_on, 1'h1);
        nap(15);
        chk(start_hold_on, 1'h1);
        nap(18);
        chk({start_hold_on, drive_enable}, 2'h1);
        u_rsc_panel.press(2'h1);
        wait_de(1'h0);
        apb(1'h1, rsc_pkg::OFF_DCB, 32'h0);
        apb(1'h1, rsc_pkg::OFF_PREX, 32'h0);
        apb(1'h1, rsc_pkg::OFF_HOLD, 32'h0);
        ctrl(8'h30);
        u_rsc_panel.press(2'h2);
        chk(track_on, 1'h1);
        track_lock <= 1'h1;
        nap(4);
        chk({track_on, drive_enable}, 2'h1);
        u_rsc_panel.press(2'h1);
        wait_de(1'h0);
        track_lock <= 1'h0;
        ctrl(8'h21);
        u_rsc_panel.lines(4'hc);
        wait_de(1'h1);
        nap(3);
        chk(drive_reverse, 1'h1);
        u_rsc_panel.press(2'h1);
        nap(6);
        chk(drive_enable, 1'h0);
        u_rsc_panel.lines(4'h0);
        wait_de(1'h0);
        u_rsc_panel.lines(4'h8);
        wait_de(1'h1);
        u_rsc_panel.lines(4'h9);
        u_rsc_panel.lines(4'h8);
        nap(4);
        chk(drive_enable, 1'h0);
        u_rsc_panel.lines(4'h0);
        ctrl(8'h61);
        u_rsc_panel.lines(4'hc);
        nap(3);
        chk({drive_enable, drive_reverse}, 2'h2);
        u_rsc_panel.lines(4'h0);
        ctrl(8'h25);
        u_rsc_panel.lines(4'h4);
        nap(3);
        chk({drive_enable, drive_reverse}, 2'h3);
        u_rsc_panel.lines(4'hc);
        wait_de(1'h0);
        ctrl(8'h29);
        u_rsc_panel.lines(4'h2);
        u_rsc_panel.lines(4'ha);
        u_rsc_panel.lines(4'h2);
        wait_de(1'h1);
        u_rsc_panel.lines(4'h0);
        wait_de(1'h0);
        u_rsc_panel.lines(4'h8);
        nap(4);
        chk(drive_enable, 1'h0);
        ctrl(8'h2d);
        u_rsc_panel.lines(4'h4);
        u_rsc_panel.lines(4'hc);
        nap(3);
        chk({drive_enable, drive_reverse}, 2'h3);
        u_rsc_panel.lines(4'h6);
        wait_de(1'h0);
        u_rsc_panel.lines(4'h0);
        ctrl(8'h22);
        u_rsc_panel.press(2'h2);
        chk(drive_enable, 1'h0);
        apb(1'h1, rsc_pkg::OFF_HOST, 32'h1);
        wait_de(1'h1);
        apb(1'h1, rsc_pkg::OFF_HOST, 32'h4);
        wait_de(1'h0);
        close_out;
    end
endmodule : rsc_run_stop_bench
